// ==== src/smbcfg_consts.vh ====
// constants of the smbus configuration target
// assumes a 100 MHz system clock and an open-drain smbus pair
// Contract
// RL1: after a start, claim only the fixed target address 60h
// RL2: abandoned transfers return to idle harmlessly
// RL3: hold the serial clock low while an internal access runs
// RL4: no single clock stretch exceeds the 25 ms smbus limit
// RL5: internal access is launched only by a received command
// RL6: writes during a busy command get a not-acknowledge
// RL7: master loads a read/write command, then four address bytes
// RL8: config mode decodes bus, device, function, extended number, offset
// RL9: memory mode decodes region byte, zero filler byte, region address
// RL10: smbus and host-bus accesses served first come first served
// RL11: exact tie at the arbiter goes to the host bus
// RL12: smbus path keeps working when internal logic hangs; code keeps cmdBusy until ringDone and nacks every later address
// RL13: field order command, count, address 3..0, data 3..0 msb first
// RL14: holding fields filled only by smbus, else unreachable
// RL15: one independent instance per target interface
// RL16: each instance owns its protocol state and holding fields
// RL17: command bit 5 selects memory (0) or configuration (1) access
// RL18: read data preceded by status: timeout, aborts, success
// RL19: every read returns a full aligned doubleword
`ifndef SMBCFG_CONSTS_VH
`define SMBCFG_CONSTS_VH
`define SMBCFG_OWN_ADDR     7'h30
`define SMBCFG_CLK_MHZ      100
`define SMBCFG_INT_TOUT_US  2000
`define SMBCFG_STRETCH_US   25000
`define SMBCFG_CNT_W        22
`define SMBCFG_IDX_CMD      4'h0
`define SMBCFG_IDX_LEN      4'h1
`define SMBCFG_IDX_L3       4'h2
`define SMBCFG_IDX_L2       4'h3
`define SMBCFG_IDX_L1       4'h4
`define SMBCFG_IDX_L0       4'h5
`define SMBCFG_IDX_LAST     4'h9
`define SMBCFG_CMD_MODE     5
`define SMBCFG_CMD_SZ_HI    3
`define SMBCFG_CMD_SZ_LO    2
`define SMBCFG_SZ_RDDW      2'h0
`define SMBCFG_SZ_WRDW      2'h3
`define SMBCFG_BE_ALL       4'hF
`define SMBCFG_BE_BYTE      4'h1
`define SMBCFG_RD_LEN       8'h05
`define SMBCFG_TX_LAST      3'h5
`define SMBCFG_BUS_MASK     8'h1F
`define SMBCFG_EXT_MASK     8'h0F
`define SMBCFG_BITS_BYTE    4'h8
`define SMBCFG_BIT_LAST     4'h7
`endif

// ==== src/smbcfg_target.v ====
// one smbus target port onto the configuration ring, plus the ring arbiter
// assumes ringDone answers each ringStart once; host fields muxed outside
`timescale 1ns/10ps
`include "smbcfg_consts.vh"
module smbcfg_target #(
    parameter [`SMBCFG_CNT_W-1:0] INT_TOUT_CYC =
        `SMBCFG_INT_TOUT_US * `SMBCFG_CLK_MHZ,
    parameter [`SMBCFG_CNT_W-1:0] STRETCH_CYC =
        `SMBCFG_STRETCH_US * `SMBCFG_CLK_MHZ
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        sclIn,
    output reg         sclOut,
    output reg         sclOe,
    input  wire        sdaIn,
    output reg         sdaOut,
    output reg         sdaOe,
    input  wire        hostReq,
    output reg         ringStart,
    output reg         ringOwnerHost,
    output reg         ringWrite,
    output reg         ringCfgMode,
    output reg  [7:0]  ringSpace,
    output reg  [7:0]  ringDevFn,
    output reg  [23:0] ringOffset,
    output reg  [31:0] ringWdata,
    output reg  [3:0]  ringByteEn,
    input  wire        ringDone,
    input  wire [31:0] ringRdata,
    input  wire        ringMasterAbort,
    input  wire        ringTargetAbort
);
    // ****************************************
    // states and helpers
    // ****************************************
    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_RX      = 3'h1;
    localparam [2:0] ST_ACK     = 3'h2;
    localparam [2:0] ST_STRETCH = 3'h3;
    localparam [2:0] ST_TX      = 3'h4;
    localparam [2:0] ST_TXACK   = 3'h5;
    localparam [2:0] ST_WAIT    = 3'h6;

    // byte enables from internal command size
    function [3:0] sizeToBe;
        input [1:0] sz;
        begin
            case (sz)
                `SMBCFG_SZ_RDDW: sizeToBe = `SMBCFG_BE_ALL;
                `SMBCFG_SZ_WRDW: sizeToBe = `SMBCFG_BE_ALL;
                default:         sizeToBe = `SMBCFG_BE_BYTE;
            endcase
        end
    endfunction

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    reg rstMeta;
    reg rstSyncN;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    reg  sclMeta;
    reg  sclSync;
    reg  sclLast;
    reg  sdaMeta;
    reg  sdaSync;
    reg  sdaLast;
    always @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclLast <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaLast <= 1'b1;
        end
        else
        begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sclLast <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaLast <= sdaSync;
        end
    end

    wire sclRise  = sclSync & ~sclLast;
    wire sclFall  = ~sclSync & sclLast;
    wire busStart = sclSync & sclLast & sdaLast & ~sdaSync;  // [RL1]
    wire busStop  = sclSync & sclLast & ~sdaLast & sdaSync;

    // ****************************************
    // per-instance holding fields and protocol state
    // ****************************************
    // private to this port, no other access path [RL14] [RL16] [RL15]
    reg [2:0]  state;
    reg [3:0]  bitCnt;
    reg [7:0]  shiftReg;
    reg [3:0]  byteIdx;
    reg        isAddr;
    reg        rdDir;
    reg        masterAck;
    reg [2:0]  txIdx;
    reg [7:0]  txShift;
    reg [7:0]  commandByte;
    reg [7:0]  transfer_length_byte;
    reg [7:0]  locator_byte_3;
    reg [7:0]  locator_byte_2;
    reg [7:0]  locator_byte_1;
    reg [7:0]  locator_byte_0;
    reg [31:0] payload;
    reg [31:0] readData;
    reg        cmdBusy;
    reg        smbPend;
    reg        smbOlder;
    reg        ringBusy;
    reg [`SMBCFG_CNT_W-1:0] waitCnt;
    reg        stTimeout;
    reg        stMasterAbort;
    reg        stTargetAbort;
    reg        stSuccess;

    wire [7:0] statusByte = {stTimeout, 1'b0, stMasterAbort,
                             stTargetAbort, 3'h0, stSuccess};   // [RL18]
    wire       cmdIsCfg   = commandByte[`SMBCFG_CMD_MODE];       // [RL17]
    wire [1:0] cmdSize    = commandByte[`SMBCFG_CMD_SZ_HI:
                                        `SMBCFG_CMD_SZ_LO];
    wire       lastByte   = (byteIdx >= `SMBCFG_IDX_L0) &&
                            ({4'h0, byteIdx} ==
                             transfer_length_byte + 8'h01);
    wire       stretchEnd = ~cmdBusy || (waitCnt >= INT_TOUT_CYC) ||
                            (waitCnt >= STRETCH_CYC - 1'b1);     // [RL4]

    function [7:0] txByteSel;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    txByteSel = `SMBCFG_RD_LEN;
                3'h1:    txByteSel = statusByte;                 // [RL18]
                3'h2:    txByteSel = readData[31:24];            // [RL19]
                3'h3:    txByteSel = readData[23:16];
                3'h4:    txByteSel = readData[15:8];
                default: txByteSel = readData[7:0];
            endcase
        end
    endfunction
    wire [7:0] firstTx = txByteSel(3'h0);
    wire [7:0] nextTx  = txByteSel(txIdx + 3'h1);

    // ****************************************
    // protocol engine, arbiter and ring request
    // ****************************************
    always @(posedge clk_sys or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            state <= ST_IDLE;   bitCnt <= 4'h0;  shiftReg <= 8'h00;
            byteIdx <= 4'h0;    isAddr <= 1'b0;  rdDir <= 1'b0;
            masterAck <= 1'b0;  txIdx <= 3'h0;   txShift <= 8'h00;
            commandByte <= 8'h00;     transfer_length_byte <= 8'h00;
            locator_byte_3 <= 8'h00;  locator_byte_2 <= 8'h00;
            locator_byte_1 <= 8'h00;  locator_byte_0 <= 8'h00;
            payload <= 32'h0;   readData <= 32'h0;
            cmdBusy <= 1'b0;    smbPend <= 1'b0; smbOlder <= 1'b0;
            ringBusy <= 1'b0;   waitCnt <= {`SMBCFG_CNT_W{1'b0}};
            stTimeout <= 1'b0;  stMasterAbort <= 1'b0;
            stTargetAbort <= 1'b0;    stSuccess <= 1'b0;
            sclOut <= 1'b0;     sclOe <= 1'b0;
            sdaOut <= 1'b0;     sdaOe <= 1'b0;
            ringStart <= 1'b0;  ringOwnerHost <= 1'b0;
            ringWrite <= 1'b0;  ringCfgMode <= 1'b0;
            ringSpace <= 8'h00; ringDevFn <= 8'h00;
            ringOffset <= 24'h0; ringWdata <= 32'h0;
            ringByteEn <= 4'h0;
        end
        else
        begin
            ringStart <= 1'b0;
            // internal watchdog runs even if the ring hangs [RL12]
            if (cmdBusy)
            begin
                if (waitCnt != {`SMBCFG_CNT_W{1'b1}})
                    waitCnt <= waitCnt + 1'b1;
                if (waitCnt == INT_TOUT_CYC)
                    stTimeout <= 1'b1;                           // [RL18]
            end
            // first come first served, tie goes to host [RL10] [RL11]
            if (smbPend && !hostReq)
                smbOlder <= 1'b1;
            if (!ringBusy && (hostReq || smbPend))
            begin
                ringBusy  <= 1'b1;
                ringStart <= 1'b1;
                if (hostReq && !(smbPend && smbOlder))
                    ringOwnerHost <= 1'b1;
                else
                begin
                    ringOwnerHost <= 1'b0;
                    smbPend       <= 1'b0;
                    smbOlder      <= 1'b0;
                end
            end
            if (ringBusy && ringDone)
            begin
                ringBusy <= 1'b0;
                if (!ringOwnerHost)
                begin
                    cmdBusy       <= 1'b0;
                    readData      <= ringRdata;
                    stMasterAbort <= ringMasterAbort;
                    stTargetAbort <= ringTargetAbort;
                    stSuccess     <= ~ringMasterAbort & ~ringTargetAbort
                                     & ~stTimeout;
                end
            end

            if (busStart)
            begin
                // restart cleans up any abandoned sequence [RL2]
                state  <= ST_RX;   isAddr <= 1'b1;
                bitCnt <= 4'h0;    byteIdx <= 4'h0;
                sdaOe  <= 1'b0;    sclOe <= 1'b0;
            end
            else if (busStop)
            begin
                state <= ST_IDLE;  sdaOe <= 1'b0;  sclOe <= 1'b0;  // [RL2]
            end
            else
            begin
                case (state)
                    ST_RX:
                    begin
                        if (sclRise)
                        begin
                            shiftReg <= {shiftReg[6:0], sdaSync};
                            bitCnt   <= bitCnt + 1'b1;
                        end
                        else if (sclFall && bitCnt == `SMBCFG_BITS_BYTE)
                        begin
                            if (isAddr)
                            begin
                                // claim own address when idle [RL1] [RL6]
                                if (shiftReg[7:1] == `SMBCFG_OWN_ADDR &&
                                    !cmdBusy)
                                begin
                                    rdDir <= shiftReg[0];
                                    sdaOe <= 1'b1;
                                    state <= ST_ACK;
                                end
                                else
                                    state <= ST_WAIT;
                            end
                            else if (cmdBusy ||
                                     byteIdx > `SMBCFG_IDX_LAST)
                                state <= ST_WAIT;                // [RL6]
                            else
                            begin
                                // fixed field order, msb first [RL13]
                                case (byteIdx)
                                    `SMBCFG_IDX_CMD:
                                        commandByte <= shiftReg;
                                    `SMBCFG_IDX_LEN:
                                        transfer_length_byte <= shiftReg;
                                    `SMBCFG_IDX_L3:
                                        locator_byte_3 <= shiftReg;
                                    `SMBCFG_IDX_L2:
                                        locator_byte_2 <= shiftReg;
                                    `SMBCFG_IDX_L1:
                                        locator_byte_1 <= shiftReg;
                                    `SMBCFG_IDX_L0:
                                        locator_byte_0 <= shiftReg;
                                    default:
                                        payload <= {payload[23:0],
                                                    shiftReg};
                                endcase
                                byteIdx <= byteIdx + 1'b1;
                                if (lastByte)
                                begin
                                    // command complete: launch [RL5] [RL7]
                                    cmdBusy   <= 1'b1;
                                    smbPend   <= 1'b1;
                                    waitCnt   <= {`SMBCFG_CNT_W{1'b0}};
                                    stTimeout <= 1'b0;
                                    stSuccess <= 1'b0;
                                    sclOe     <= 1'b1;           // [RL3]
                                    state     <= ST_STRETCH;
                                end
                                else
                                begin
                                    sdaOe <= 1'b1;
                                    state <= ST_ACK;
                                end
                            end
                        end
                    end
                    ST_STRETCH:
                    begin
                        if (stretchEnd)
                        begin
                            sclOe <= 1'b0;                       // [RL4]
                            sdaOe <= 1'b1;
                            state <= ST_ACK;
                        end
                    end
                    ST_ACK:
                    begin
                        if (sclFall)
                        begin
                            bitCnt <= 4'h0;
                            if (isAddr && rdDir)
                            begin
                                txIdx   <= 3'h0;
                                sdaOe   <= ~firstTx[7];
                                txShift <= {firstTx[6:0], 1'b0};
                                state   <= ST_TX;
                            end
                            else
                            begin
                                sdaOe <= 1'b0;
                                state <= ST_RX;
                            end
                            isAddr <= 1'b0;
                        end
                    end
                    ST_TX:
                    begin
                        if (sclFall)
                        begin
                            bitCnt <= bitCnt + 1'b1;
                            if (bitCnt == `SMBCFG_BIT_LAST)
                            begin
                                sdaOe <= 1'b0;
                                state <= ST_TXACK;
                            end
                            else
                            begin
                                sdaOe   <= ~txShift[7];
                                txShift <= {txShift[6:0], 1'b0};
                            end
                        end
                    end
                    ST_TXACK:
                    begin
                        if (sclRise)
                            masterAck <= ~sdaSync;
                        else if (sclFall)
                        begin
                            if (masterAck && txIdx != `SMBCFG_TX_LAST)
                            begin
                                bitCnt  <= 4'h0;
                                txIdx   <= txIdx + 1'b1;
                                sdaOe   <= ~nextTx[7];
                                txShift <= {nextTx[6:0], 1'b0};
                                state   <= ST_TX;
                            end
                            else
                                state <= ST_WAIT;
                        end
                    end
                    ST_WAIT:
                        sdaOe <= 1'b0;
                    default:
                    begin
                        sdaOe <= 1'b0;
                        sclOe <= 1'b0;
                    end
                endcase
            end

            // decode fields for the ring request [RL8] [RL9]
            if (smbPend && !ringBusy && !(hostReq && !smbOlder))
            begin
                ringWrite   <= (cmdSize != `SMBCFG_SZ_RDDW);
                ringCfgMode <= cmdIsCfg;                         // [RL17]
                ringByteEn  <= sizeToBe(cmdSize);                // [RL19]
                ringWdata   <= payload;
                if (cmdIsCfg)
                begin
                    ringSpace  <= locator_byte_3 & `SMBCFG_BUS_MASK;
                    ringDevFn  <= locator_byte_2;
                    ringOffset <= {12'h000,
                                   locator_byte_1[3:0], locator_byte_0};
                end
                else
                begin
                    ringSpace  <= locator_byte_3;
                    ringDevFn  <= 8'h00;
                    ringOffset <= {locator_byte_2, locator_byte_1,
                                   locator_byte_0};
                end
            end
        end
    end
endmodule

// ==== testbench/smbcfg_target_asserts.sv ====
// concurrent checks on the ports of one smbus configuration target
// bound from the bench top, given STRETCH_CYC
`timescale 1ns/10ps
`include "smbcfg_consts.vh"
module smbcfg_target_asserts #(
    parameter [`SMBCFG_CNT_W-1:0] STRETCH_CYC = 400
) (
    input wire        clk_sys,
    input wire        rst_n,
    input wire        sclOut,
    input wire        sclOe,
    input wire        sdaOut,
    input wire        hostReq,
    input wire        ringStart,
    input wire        ringOwnerHost,
    input wire        ringWrite,
    input wire        ringCfgMode,
    input wire [7:0]  ringSpace,
    input wire [7:0]  ringDevFn,
    input wire [23:0] ringOffset,
    input wire [3:0]  ringByteEn,
    input wire        sdaOe
);
    // ****************************************
    // stretch length counter
    // ****************************************
    reg [`SMBCFG_CNT_W-1:0] lowCnt;
    wire                    smbGo = ringStart && !ringOwnerHost;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n || !sclOe)
            lowCnt <= {`SMBCFG_CNT_W{1'b0}};
        else
            lowCnt <= lowCnt + 1'b1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_pins_open_drain: assert property (!sclOut && !sdaOut)
        else $error("pin output value not low");
    a_stretch_bound: assert property (lowCnt <= STRETCH_CYC)
        else $error("clock stretch too long");
    a_stretch_access: assert property (smbGo && !ringWrite |-> sclOe)
        else $error("internal access without stretch");
    a_release_ack: assert property ($fell(sclOe) |-> sdaOe)
        else $error("stretch ended without ack");
    a_cfg_decode: assert property (smbGo && ringCfgMode |->
        ringSpace[7:5] == 3'h0 && ringOffset[23:12] == 12'h000)
        else $error("config address decode wrong");
    a_mem_decode: assert property (smbGo && !ringCfgMode |->
        ringDevFn == 8'h00)
        else $error("memory filler not zero");
    a_read_dword: assert property (smbGo && !ringWrite |->
        ringByteEn == 4'hF)
        else $error("read not a full dword");
    a_host_owner: assert property (ringStart && ringOwnerHost |->
        hostReq)
        else $error("host grant without request");
endmodule

// ==== testbench/smbcfg_mst.sv ====
// behavioural smbus management master
// assumes the bench resolves the pulled-up lines
`timescale 1ns/10ps
module smbcfg_mst (
    input wire sclLine,
    input wire sdaLine,
    output reg sclLow,
    output reg sdaLow
);
    initial
    begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end
    // ****************************************
    // bit level, 160 ns per bit
    // ****************************************
    task scl_rise;
        integer n;
    begin
        sclLow = 1'b0;
        n = 0;
        while (!sclLine && n < 1000)
        begin
            #10;
            n = n + 1;
        end
        if (n == 1000)
            smbcfg_target_tb_top.timed_out;
        #80;
    end
    endtask
    task bit_io(input b, output s);
    begin
        sdaLow = !b;
        #40;
        scl_rise;
        s = sdaLine;
        sclLow = 1'b1;
        #40;
    end
    endtask
    task start_cond;
    begin
        sdaLow = 1'b0;
        #40;
        scl_rise;
        sdaLow = 1'b1;
        #80;
        sclLow = 1'b1;
        #40;
    end
    endtask
    task stop_cond;
    begin
        sdaLow = 1'b1;
        #40;
        scl_rise;
        sdaLow = 1'b0;
        #160;
    end
    endtask
    task send_byte(input [7:0] d, output nak);
        integer i;
        reg     s;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(d[i], s);
        bit_io(1'b1, nak);
    end
    endtask
    task recv_byte(input ackIt, output [7:0] d);
        integer i;
        reg     s;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(1'b1, d[i]);
        bit_io(!ackIt, s);
    end
    endtask
endmodule

// ==== testbench/smbcfg_target_tb_top.sv ====
// self-checking bench of the smbus configuration target
// assumes the master model and a ring responder built here
`timescale 1ns/10ps
module smbcfg_target_tb_top;
    reg         clk_sys;
    reg         rst_n;
    reg         hostReq;
    reg         hostDone;
    reg         ringDone = 1'b0;
    reg  [31:0] ringRdata;
    reg         ringMasterAbort;
    reg         ringTargetAbort;
    wire        sclOut, sclOe, sdaOut, sdaOe, sclLow, sdaLow;
    wire        ringStart, ringOwnerHost, ringWrite, ringCfgMode;
    wire [7:0]  ringSpace, ringDevFn;
    wire [23:0] ringOffset;
    wire [31:0] ringWdata;
    wire [3:0]  ringByteEn;
    wire        sclLine = !(sclOe || sclLow);
    wire        sdaLine = !(sdaOe || sdaLow);
    integer     error_cnt, check_count, dly;
    reg  [7:0]  startCnt;
    reg  [45:0] cap;
    reg  [31:0] capW;
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    smbcfg_target #(.INT_TOUT_CYC(200), .STRETCH_CYC(400)) smbcfg_target_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclIn(sclLine),
        .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .hostReq(hostReq), .ringStart(ringStart),
        .ringOwnerHost(ringOwnerHost), .ringWrite(ringWrite),
        .ringCfgMode(ringCfgMode), .ringSpace(ringSpace),
        .ringDevFn(ringDevFn), .ringOffset(ringOffset),
        .ringWdata(ringWdata), .ringByteEn(ringByteEn),
        .ringDone(ringDone), .ringRdata(ringRdata),
        .ringMasterAbort(ringMasterAbort),
        .ringTargetAbort(ringTargetAbort));
    smbcfg_mst smbcfg_mst_i (.sclLine(sclLine), .sdaLine(sdaLine),
        .sclLow(sclLow), .sdaLow(sdaLow));
    // ****************************************
    // ring responder, 30-cycle answer
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (ringStart && !ringOwnerHost)
        begin
            dly = 30;
            startCnt <= startCnt + 8'h01;
            cap <= {ringWrite, ringCfgMode, ringSpace, ringDevFn,
                    ringOffset, ringByteEn};
            capW <= ringWdata;
        end
        else if (dly > 0)
            dly = dly - 1;
        ringDone <= #1 (dly == 1) || hostDone;
    end
    task check(input [45:0] seen, input [45:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task complete_run;
    begin
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task timed_out;
    begin
        check(1'b1, 1'b0);
        complete_run;
    end
    endtask
    task wr_block(input [79:0] b, input integer n, output nk);
        integer i;
        reg     k;
    begin
        smbcfg_mst_i.start_cond;
        smbcfg_mst_i.send_byte(8'h60, nk);
        for (i = 0; i < n; i = i + 1)
        begin
            smbcfg_mst_i.send_byte(b[79-8*i -: 8], k);
            nk = nk | k;
        end
    end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_foreign;
        reg k;
    begin
        smbcfg_mst_i.start_cond;
        smbcfg_mst_i.send_byte(8'h62, k);
        smbcfg_mst_i.stop_cond;
        check(k, 1'b1);
    end
    endtask
    task t_abandon_then_cfg;
        reg       k;
        reg [7:0] s0;
    begin
        s0 = startCnt;
        wr_block({32'hEE08E02A, 48'h0}, 4, k);
        smbcfg_mst_i.stop_cond;
        check(startCnt, s0);
        wr_block(80'hEE08E02AF534DEADBEEF, 10, k);
        smbcfg_mst_i.stop_cond;
        check(k, 1'b0);
        check(startCnt, s0 + 8'h01);
        check(cap, {2'b11, 16'h002A, 24'h000534, 4'hF});
        check(capW, 32'hDEADBEEF);
    end
    endtask
    task t_read(input ma, input ta);
        reg        k;
        reg [7:0]  d;
        reg [47:0] e;
        integer    i;
    begin
        ringMasterAbort = ma;
        ringTargetAbort = ta;
        e = {8'h05, 2'b00, ma, ta, 3'b000, !(ma || ta), 32'h11223344};
        wr_block({48'hC20408123456, 32'h0}, 6, k);
        check(k, 1'b0);
        check(cap, {2'b00, 16'h0800, 24'h123456, 4'hF});
        smbcfg_mst_i.start_cond;
        smbcfg_mst_i.send_byte(8'h61, k);
        for (i = 0; i < 6; i = i + 1)
        begin
            smbcfg_mst_i.recv_byte(i < 5, d);
            if (i < 2 || !(ma || ta))
                check(d, e[47-8*i -: 8]);
        end
        smbcfg_mst_i.stop_cond;
    end
    endtask
    task t_busy;
        reg       k;
        reg [7:0] s0;
    begin
        @(posedge clk_sys) #1 hostReq = 1'b1;
        repeat (5) @(posedge clk_sys);
        s0 = startCnt;
        wr_block(80'hCE0808000102A1B2C3D4, 10, k);
        smbcfg_mst_i.stop_cond;
        check(k, 1'b0);
        check(startCnt, s0);
        wr_block(80'h0, 0, k);
        smbcfg_mst_i.stop_cond;
        check(k, 1'b1);
        @(posedge clk_sys) #1 hostDone = 1'b1;
        @(posedge clk_sys) #1 hostDone = 1'b0;
        @(posedge clk_sys) #1 hostReq = 1'b0;
        repeat (50) @(posedge clk_sys);
        check(startCnt, s0 + 8'h01);
        check(cap, {2'b10, 16'h0800, 24'h000102, 4'hF});
        check(capW, 32'hA1B2C3D4);
    end
    endtask
    initial
    begin
        error_cnt = 0;
        check_count = 0;
        dly = 0;
        startCnt = 8'h00;
        rst_n = 1'b0;
        hostReq = 1'b0;
        hostDone = 1'b0;
        ringRdata = 32'h11223344;
        ringMasterAbort = 1'b0;
        ringTargetAbort = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge clk_sys);
        t_foreign;
        t_abandon_then_cfg;
        t_read(1'b0, 1'b0);
        t_read(1'b1, 1'b0);
        t_read(1'b0, 1'b1);
        t_busy;
        complete_run;
    end
endmodule
bind smbcfg_target smbcfg_target_asserts #(.STRETCH_CYC(STRETCH_CYC))
    smbcfg_target_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .hostReq(hostReq), .ringStart(ringStart),
    .ringOwnerHost(ringOwnerHost), .ringWrite(ringWrite),
    .ringCfgMode(ringCfgMode), .ringSpace(ringSpace),
    .ringDevFn(ringDevFn), .ringOffset(ringOffset),
    .ringByteEn(ringByteEn));
